// File: sim/dtc_timer_assertions.sv
// Purpose: port-level checks of the dual timer
// Assumes: classic Wishbone slave, registers in the low byte
// Notes:   mode bits are shadowed from bus writes, not read from inside
`include "dtc_map.svh"
module dtc_timer_chk #(
  parameter int ADR_W = 18
) (
  // clock and reset
  input wire logic             i_clk_sys,
  input wire logic             i_reset_n,
  // bus
  input wire logic             i_wb_cyc,
  input wire logic             i_wb_stb,
  input wire logic             i_wb_we,
  input wire logic [ADR_W-1:0] i_wb_adr,
  input wire logic [3:0]       i_wb_sel,
  input wire logic [31:0]      i_wb_dat,
  input wire logic [31:0]      o_wb_dat,
  input wire logic             o_wb_ack,
  // pin and events
  input wire logic             o_timer_out,
  input wire logic             o_timer_out_oe,
  input wire logic             o_match_irq_a,
  input wire logic             o_match_irq_b
);
  logic [7:0]  ma_reg;
  logic [7:0]  mb_reg;
  logic        take;
  logic        bad;
  logic [15:0] idx;
  assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign idx  = 16'(i_wb_adr[ADR_W-1:2]);
  assign bad  = !({ma_reg[1], mb_reg[2:1]} inside {3'h0, 3'h5, 3'h3, 3'h2});
  // ****
  // mode shadow
  // ****
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ma_reg <= 8'h00;
      mb_reg <= 8'h00;
    end else if (take && i_wb_we && i_wb_sel[0]) begin
      if (idx == `DTC_IDX_MODE_A) ma_reg <= i_wb_dat[7:0];
      if (idx == `DTC_IDX_MODE_B) mb_reg <= i_wb_dat[7:0];
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  a_ack_prompt: assert property (take |=> o_wb_ack) else $error("ack missing");
  a_rd_upper: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_pin_port: assert property (!o_timer_out_oe |-> !o_timer_out)
    else $error("pin driven while disabled");
  a_oe_write: assert property (take && i_wb_we && i_wb_sel[0] && idx == `DTC_IDX_MODE_B
    |=> ##1 o_timer_out_oe == $past(i_wb_dat[0], 2)) else $error("enable not followed");
  a_oe_low_start: assert property ($rose(o_timer_out_oe) |-> !o_timer_out)
    else $error("output not low at enable");
  a_casc_no_a: assert property ({ma_reg[1], mb_reg[2:1]} == 3'h5 && $past(ma_reg[1])
    && $past(mb_reg[2:1]) == 2'h1 |-> !o_match_irq_a) else $error("irq a in cascade");
  a_stop_a: assert property (!ma_reg[7] && !$past(ma_reg[7]) |-> !o_match_irq_a)
    else $error("irq a while stopped");
  a_stop_b: assert property (!mb_reg[7] && !$past(mb_reg[7]) |-> !o_match_irq_b)
    else $error("irq b while stopped");
  a_bad_quiet: assert property (bad && $past(bad) |-> !o_match_irq_a && !o_match_irq_b)
    else $error("event in prohibited mode");
endmodule

// File: sim/tb_top.sv
// Purpose: self-checking bench of the dual timer
// Assumes: one system clock, bus master keeps one idle cycle between requests
// Notes:   intervals are measured between match pulses
`include "dtc_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        rst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [17:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        pin;
  logic        oe;
  logic        irq_a;
  logic        irq_b;
  int          n_mismatch;
  int          samples_checked;
  int          n;
  int          w;
  int          k;
  logic [7:0]  c;
  logic [7:0]  lo_w;
  logic [7:0]  hi_w;
  logic [31:0] r;
  logic [15:0] ridx [9];
  logic [2:0]  bad [4];
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  dtc_timer #(.ADR_W(18)) dtc_timer_inst (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .o_timer_out(pin), .o_timer_out_oe(oe), .o_match_irq_a(irq_a),
    .o_match_irq_b(irq_b)
  );
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic hang();
    n_mismatch++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    results();
  endtask
  // one classic cycle; waits for ack, never assumes a latency
  task automatic wb(input logic wr_en, input logic [15:0] i, input logic [7:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int t;
    t = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= wr_en;
    adr  <= {i, 2'b00};
    sel  <= s;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk);
      t++;
      if (t > 20) hang();
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    logic [31:0] x;
    wb(1'b1, i, d, 4'hF, x);
  endtask
  task automatic rdchk(input logic [15:0] i, input logic [7:0] e, input string what);
    logic [31:0] d;
    wb(1'b0, i, 8'h00, 4'hF, d);
    chk(d, {24'h000000, e}, what);
  endtask
  task automatic gap(input bit b, output int p);
    p = 0;
    do begin
      @(posedge clk);
      p++;
      if (p > 9000) hang();
    end while ((b ? irq_b : irq_a) !== 1'b1);
  endtask
  // first gap only aligns to the free-running prescaler
  task automatic per(input bit b, output int p);
    gap(b, p);
    gap(b, p);
  endtask
  task automatic hiw(output int h);
    int t;
    for (t = 0; t < 2000 && pin !== 1'b0; t++) @(posedge clk);
    for (t = 0; t < 2000 && pin !== 1'b1; t++) @(posedge clk);
    for (h = 0; h < 2000 && pin === 1'b1; h++) @(posedge clk);
  endtask
  function automatic int divb(input logic [7:0] s);
    case (s)
      8'h00: return 1;
      8'h02: return 2;
      8'h04: return 8;
      8'h05: return 16;
      default: return 4;
    endcase
  endfunction
  // ****
  // main sequence
  // ****
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = '0;
    wdat = '0;
    rst_n = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    ridx = '{`DTC_IDX_MODE_A, `DTC_IDX_MODE_B, `DTC_IDX_CARRIER, `DTC_IDX_CMP_A,
             `DTC_IDX_CMP_B_LO, `DTC_IDX_CMP_B_HI, `DTC_IDX_CNT_A, `DTC_IDX_CNT_B, 16'h1234};
    bad = '{3'h1, 3'h4, 3'h6, 3'h7};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    k = $urandom(32'h7F4EEE02);
    foreach (ridx[i]) rdchk(ridx[i], 8'h00, "reset value");
    wr(`DTC_IDX_CARRIER, 8'hFF);
    rdchk(`DTC_IDX_CARRIER, 8'h07, "carrier mask");
    wr(`DTC_IDX_MODE_A, 8'hFF);
    rdchk(`DTC_IDX_MODE_A, 8'h9A, "mode a mask");
    wr(`DTC_IDX_MODE_B, 8'hFF);
    rdchk(`DTC_IDX_MODE_B, 8'hBF, "mode b mask");
    wr(`DTC_IDX_CARRIER, 8'h00);
    rdchk(`DTC_IDX_CARRIER, 8'h01, "nrz locked");
    wr(`DTC_IDX_MODE_B, 8'h00);
    wr(`DTC_IDX_MODE_A, 8'h00);
    wr(`DTC_IDX_CARRIER, 8'h00);
    rdchk(`DTC_IDX_CARRIER, 8'h00, "nrz free");
    wb(1'b1, `DTC_IDX_MODE_A, 8'hFF, 4'hE, r);
    rdchk(`DTC_IDX_MODE_A, 8'h00, "sel ignored");
    wr(16'h1234, 8'hFF);
    rdchk(16'h1234, 8'h00, "unmapped");
    $display("test registers done");
    for (c = 0; c < 6; c++) begin
      lo_w = 8'($urandom_range(7));
      wr(`DTC_IDX_CMP_B_LO, lo_w);
      wr(`DTC_IDX_MODE_B, 8'h80 | (c << 3));
      per(1'b1, n);
      chk(n, (lo_w + 1) * divb(c), "b interval");
      wr(`DTC_IDX_MODE_B, 8'h00);
      rdchk(`DTC_IDX_CNT_B, 8'h00, "b cleared");
    end
    wr(`DTC_IDX_CMP_B_LO, 8'h03);
    wr(`DTC_IDX_MODE_B, 8'h80);
    for (c = 0; c < 3; c++) begin
      k = $urandom_range(3);
      wr(`DTC_IDX_CMP_A, 8'(k));
      wr(`DTC_IDX_MODE_A, 8'h80 | (c << 3));
      per(1'b0, n);
      chk(n, (k + 1) * (c == 0 ? 64 : c == 1 ? 256 : 4), "a interval");
      wr(`DTC_IDX_MODE_A, 8'h00);
      rdchk(`DTC_IDX_CNT_A, 8'h00, "a cleared");
    end
    wr(`DTC_IDX_MODE_B, 8'h00);
    $display("test discrete done");
    wr(`DTC_IDX_CMP_A, 8'h01);
    wr(`DTC_IDX_CMP_B_LO, 8'h02);
    // run_a off and a slow clksel_a: both must be overridden
    wr(`DTC_IDX_MODE_A, 8'h0A);
    wr(`DTC_IDX_MODE_B, 8'h82);
    per(1'b1, n);
    chk(n, 16'h0102 + 1, "cascade interval");
    wr(`DTC_IDX_MODE_B, 8'h02);
    rdchk(`DTC_IDX_CNT_A, 8'h00, "cascade a cleared");
    $display("test cascade done");
    hi_w = 8'($urandom_range(9, 2));
    lo_w = 8'($urandom_range(9, 2));
    wr(`DTC_IDX_CMP_B_LO, lo_w);
    wr(`DTC_IDX_CMP_B_HI, hi_w);
    wr(`DTC_IDX_CMP_A, 8'h00);
    for (k = 0; k < 2; k++) begin
      wr(`DTC_IDX_MODE_A, 8'h00);
      wr(`DTC_IDX_CARRIER, 8'h03);
      wr(`DTC_IDX_MODE_A, 8'h98);
      wr(`DTC_IDX_MODE_B, k ? 8'h85 : 8'h87);
      per(1'b1, n);
      chk(n, lo_w + hi_w + 2, "phase pair");
      per(1'b0, w);
      chk(w, lo_w + hi_w + 2, "a on carrier clock");
      hiw(w);
      chk(w, hi_w + 1, "high width");
      wr(`DTC_IDX_MODE_B, 8'h00);
    end
    wr(`DTC_IDX_CARRIER, 8'h07);
    wr(`DTC_IDX_MODE_B, 8'h87);
    wr(`DTC_IDX_CARRIER, 8'h07);
    gap(1'b0, n);
    repeat (3) @(posedge clk);
    for (k = 0; k < 24; k++) begin
      chk(pin, 1'b1, "steady high");
      @(posedge clk);
    end
    wr(`DTC_IDX_CARRIER, 8'h04);
    gap(1'b0, n);
    repeat (3) @(posedge clk);
    chk(pin, 1'b0, "nrz low");
    rdchk(`DTC_IDX_CARRIER, 8'h04, "nrz moved");
    wr(`DTC_IDX_CARRIER, 8'h06);
    gap(1'b0, n);
    repeat (3) @(posedge clk);
    chk(pin, 1'b1, "nrz high");
    rdchk(`DTC_IDX_CARRIER, 8'h07, "nrz moved");
    wr(`DTC_IDX_MODE_B, 8'h06);
    rdchk(`DTC_IDX_CARRIER, 8'h05, "next bit lost");
    rdchk(`DTC_IDX_CNT_B, 8'h00, "b cleared");
    $display("test carrier done");
    wr(`DTC_IDX_CMP_A, 8'hFF);
    wr(`DTC_IDX_CMP_B_LO, 8'hFF);
    foreach (bad[i]) begin
      wr(`DTC_IDX_MODE_A, 8'h80 | (bad[i][2] << 1));
      wr(`DTC_IDX_MODE_B, 8'h80 | (bad[i][1:0] << 1));
      repeat (100) @(posedge clk);
      rdchk(`DTC_IDX_CNT_A, 8'h00, "bad mode a");
      rdchk(`DTC_IDX_CNT_B, 8'h00, "bad mode b");
    end
    $display("test prohibited done");
    results();
  end
endmodule
bind dtc_timer dtc_timer_chk #(.ADR_W(ADR_W)) dtc_timer_chk_inst (
  .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_timer_out(o_timer_out),
  .o_timer_out_oe(o_timer_out_oe), .o_match_irq_a(o_match_irq_a), .o_match_irq_b(o_match_irq_b)
);

// File: src/dtc_map.svh
// Purpose: register map, field positions, codes and reset values of the dual timer
// Assumes: 32-bit classic Wishbone, byte address = 4 x register index
// Notes:   8-bit registers sit in the low byte, upper bits read as zero
//
// How it works
// [R1] carrier or pwm mode: counter_b clears on reset, stop, either match, overflow
// [R2] run_a 0 clears and halts counter_a; run_a 1 starts it; bit 7
// [R3] clksel_a picks main_clk/64, main_clk/256, timer b match, or carrier clock
// [R4] mode bits 000 discrete, 101 cascade, 011 carrier, 010 pwm; rest prohibited
// [R5] cascade mode ignores run_a; run_b alone starts and stops both counters
// [R6] cascade mode forces timer a clock to timer b output, ignoring clksel_a
// [R7] software programs the mode across both control registers together
// [R8] software writes zero to reserved bits of both mode control registers
// [R9] run_b 0 clears and halts counter_b, also counter_a in cascade; 1 starts
// [R10] clksel_b picks main_clk, /4, /2, /4, /8, /16; other codes prohibited
// [R11] out_enable_b 0 leaves pin in port mode; 1 drives timer b output
// [R12] software writes carrier_out_ctrl with whole-byte accesses only
// [R13] nrz_now 1: carrier on pin if remote_level_sel 0, steady high if 1
// [R14] each timer a match copies nrz_next into nrz_now
// [R15] nrz_now 0 stops the carrier and drives the output low
// [R16] nrz_now writable only while out_enable_b is 0
// [R17] restarting the carrier generator loses nrz_next; software reloads it
// [R18] software loads compares and nrz bits before enabling carrier mode
// [R19] software keeps bits 3 to 7 of carrier_out_ctrl at zero
// [R20] carrier/pwm: compare_b_low sets low width, compare_b_high high width and irq
// [R21] cascade: match_irq_b only on simultaneous double match; match_irq_a never
// [R22] timer output starts low when out_enable_b is set
// [R23] carrier toggles on each compare match; pin is carrier gated by nrz bits
// [R24] reserved bits read zero and writes to them have no effect
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH

// ****************************************
// register indices
// ****************************************
`define DTC_IDX_W          16
`define DTC_IDX_MODE_A     16'hFF65
`define DTC_IDX_MODE_B     16'hFF69
`define DTC_IDX_CARRIER    16'hFF6A
`define DTC_IDX_CMP_A      16'hFF70
`define DTC_IDX_CMP_B_LO   16'hFF71
`define DTC_IDX_CMP_B_HI   16'hFF72
`define DTC_IDX_CNT_A      16'hFF73
`define DTC_IDX_CNT_B      16'hFF74

// ****************************************
// fields, masks, reset values
// ****************************************
`define DTC_BIT_RUN        7
`define DTC_BIT_CLKA_HI    4
`define DTC_BIT_CLKA_LO    3
`define DTC_BIT_MODE_A     1
`define DTC_CLKB_MSB       5
`define DTC_CLKB_LSB       3
`define DTC_MODEB_MSB      2
`define DTC_MODEB_LSB      1
`define DTC_BIT_OE         0
`define DTC_BIT_RMC        2
`define DTC_BIT_NRZ_NEXT   1
`define DTC_BIT_NRZ_NOW    0
`define DTC_MASK_MODE_A    8'h9A
`define DTC_MASK_MODE_B    8'hBF
`define DTC_MASK_CARRIER   8'h07
`define DTC_RST_REG        8'h00
`define DTC_CNT_MAX        8'hFF

// ****************************************
// mode and clock codes
// ****************************************
`define DTC_MODE_DISC      3'h0
`define DTC_MODE_CASC      3'h5
`define DTC_MODE_CARR      3'h3
`define DTC_MODE_PWM       3'h2
`define DTC_CLKA_DIV64     2'h0
`define DTC_CLKA_DIV256    2'h1
`define DTC_CLKA_MATCH     2'h2
`define DTC_CLKA_CARR      2'h3
`define DTC_EXP_A64        6
`define DTC_EXP_A256       8
`define DTC_CLKB_DIV1      3'h0
`define DTC_CLKB_DIV4      3'h1
`define DTC_CLKB_DIV2      3'h2
`define DTC_CLKB_DIV4B     3'h3
`define DTC_CLKB_DIV8      3'h4
`define DTC_CLKB_DIV16     3'h5
`define DTC_PRE_W          8

`endif

// File: src/dtc_pkg.sv
// Purpose: shared types of the dual timer
// Assumes: dtc_map.svh holds every number
// Notes:   mode decode is a function so every user sees the same table
`include "dtc_map.svh"
package dtc_pkg;

  typedef enum logic [4:0] {
    DTC_DISC = 5'b00001,
    DTC_CASC = 5'b00010,
    DTC_CARR = 5'b00100,
    DTC_PWM  = 5'b01000,
    DTC_BAD  = 5'b10000
  } dtc_mode_t;

  // prohibited combinations land in DTC_BAD and halt both counters
  function automatic dtc_mode_t dtc_mode_dec(input logic [2:0] code);
    case (code)
      `DTC_MODE_DISC: dtc_mode_dec = DTC_DISC; // R4
      `DTC_MODE_CASC: dtc_mode_dec = DTC_CASC; // R4
      `DTC_MODE_CARR: dtc_mode_dec = DTC_CARR; // R4
      `DTC_MODE_PWM:  dtc_mode_dec = DTC_PWM;  // R4
      default:        dtc_mode_dec = DTC_BAD;  // R4
    endcase
  endfunction

endpackage

// File: src/dtc_prescaler.sv
// Purpose: free-running divider of main_clk giving one-cycle ticks at 2^k
// Assumes: runs on every rising edge of the system clock
// Notes:   o_tick[0] is always high, o_tick[k] pulses once per 2^k cycles
module dtc_prescaler #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset_n,
  // ticks
  output logic [W:0]        o_tick
);

  logic [W-1:0] div_reg;

  initial begin
    if (W < 1) begin
      $error("dtc_prescaler: W must be at least 1");
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign o_tick[0] = 1'b1;

  genvar k;
  generate
    for (k = 1; k <= W; k++) begin : g_tick
      assign o_tick[k] = &div_reg[k-1:0];
    end
  endgenerate

endmodule

// File: src/dtc_timer.sv
// Purpose: two 8-bit timers with cascade, carrier generator and pwm modes
// Assumes: classic Wishbone slave, one clock, registers in the low byte
// Notes:   counts advance on prescaler ticks of the system clock
//
// Added by the designer: the Wishbone interface to the registers.
`include "dtc_map.svh"
module dtc_timer
  import dtc_pkg::*;
#(
  parameter int ADR_W = 18
) (
  // clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_reset_n,
  // wishbone slave
  input  wire logic              i_wb_cyc,
  input  wire logic              i_wb_stb,
  input  wire logic              i_wb_we,
  input  wire logic [ADR_W-1:0]  i_wb_adr,
  input  wire logic [3:0]        i_wb_sel,
  input  wire logic [31:0]       i_wb_dat,
  output logic [31:0]            o_wb_dat,
  output logic                   o_wb_ack,
  // timer output pin
  output logic                   o_timer_out,
  output logic                   o_timer_out_oe,
  // match events
  output logic                   o_match_irq_a,
  output logic                   o_match_irq_b
);
  import dtc_pkg::*;

  initial begin
    if (ADR_W < `DTC_IDX_W + 2) begin
      $error("dtc_timer: ADR_W too small for the register indices");
    end
  end

  // ****************************************
  // declarations
  // ****************************************
  logic [7:0]           mode_a_reg;
  logic [7:0]           mode_b_reg;
  logic                 rmc_reg;
  logic                 nrz_next_reg;
  logic                 nrz_now_reg;
  logic [7:0]           cmp_a_reg;
  logic [7:0]           cmp_b_lo_reg;
  logic [7:0]           cmp_b_hi_reg;
  logic [7:0]           cnt_a_reg;
  logic [7:0]           cnt_b_reg;
  logic                 lvl_reg;
  logic                 ack_reg;
  logic [31:0]          dat_reg;
  logic                 pin_reg;
  logic                 oe_reg;
  logic                 irq_a_reg;
  logic                 irq_b_reg;
  logic [`DTC_PRE_W:0]  tick;
  logic                 wb_hit;
  logic                 wr;
  logic [`DTC_IDX_W-1:0] idx;
  logic [7:0]           wdat;
  logic                 wr_mode_a;
  logic                 wr_mode_b;
  logic                 wr_carr;
  dtc_mode_t            mode;
  logic                 casc;
  logic                 shaped;
  logic                 run_a_eff;
  logic                 run_b_eff;
  logic                 tick_b;
  logic [7:0]           lim_b;
  logic                 hit_b;
  logic                 carry_b;
  logic                 both_match;
  logic                 carr_rise;
  logic                 tick_a;
  logic                 match_a;
  logic                 irq_b_evt;
  logic                 oe_rise;
  logic                 pin_next;
  logic [7:0]           rd_byte;

  // ****************************************
  // clock dividers
  // ****************************************
  dtc_prescaler #(
    .W (`DTC_PRE_W)
  ) u_pre (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .o_tick    (tick)
  );

  // timer b count clock; prohibited codes give no tick
  function automatic logic clkb_tick(input logic [2:0] sel,
                                     input logic [`DTC_PRE_W:0] t);
    case (sel)
      `DTC_CLKB_DIV1:  clkb_tick = t[0];
      `DTC_CLKB_DIV4:  clkb_tick = t[2];
      `DTC_CLKB_DIV2:  clkb_tick = t[1];
      `DTC_CLKB_DIV4B: clkb_tick = t[2];
      `DTC_CLKB_DIV8:  clkb_tick = t[3];
      `DTC_CLKB_DIV16: clkb_tick = t[4];
      default:         clkb_tick = 1'b0;
    endcase
  endfunction

  // ****************************************
  // bus decode
  // ****************************************
  // a request is taken once; ack drops in the following cycle
  assign wb_hit    = i_wb_cyc & i_wb_stb & ~ack_reg;
  assign wr        = wb_hit & i_wb_we & i_wb_sel[0];
  assign idx       = i_wb_adr[`DTC_IDX_W+1:2];
  assign wdat      = i_wb_dat[7:0];
  assign wr_mode_a = wr & (idx == `DTC_IDX_MODE_A);
  assign wr_mode_b = wr & (idx == `DTC_IDX_MODE_B);
  assign wr_carr   = wr & (idx == `DTC_IDX_CARRIER); // R12

  // ****************************************
  // mode and run decode
  // ****************************************
  assign mode   = dtc_mode_dec({mode_a_reg[`DTC_BIT_MODE_A],
                                mode_b_reg[`DTC_MODEB_MSB:`DTC_MODEB_LSB]}); // R7
  assign casc   = (mode == DTC_CASC);
  assign shaped = (mode == DTC_CARR) | (mode == DTC_PWM);

  assign run_b_eff = mode_b_reg[`DTC_BIT_RUN] & (mode != DTC_BAD); // R9
  // cascade hands both counters to run_b
  assign run_a_eff = (casc ? mode_b_reg[`DTC_BIT_RUN]
                           : mode_a_reg[`DTC_BIT_RUN]) & (mode != DTC_BAD); // R5 R2

  // ****************************************
  // timer b compare
  // ****************************************
  assign tick_b = run_b_eff &
                  clkb_tick(mode_b_reg[`DTC_CLKB_MSB:`DTC_CLKB_LSB], tick); // R10
  // in carrier and pwm the high phase compares against compare_b_high; otherwise compare_b_low
  assign lim_b      = (shaped & lvl_reg) ? cmp_b_hi_reg : cmp_b_lo_reg; // R20
  assign hit_b      = tick_b & ~casc & (cnt_b_reg == lim_b);
  assign carry_b    = tick_b & casc & (cnt_b_reg == `DTC_CNT_MAX);
  assign both_match = tick_b & casc & (cnt_b_reg == cmp_b_lo_reg)
                      & (cnt_a_reg == cmp_a_reg); // R21
  assign carr_rise  = hit_b & shaped & ~lvl_reg;

  // ****************************************
  // timer a clock and compare
  // ****************************************
  always_comb begin
    tick_a = 1'b0;
    if (casc) begin
      tick_a = carry_b & ~both_match; // R6
    end else begin
      case ({mode_a_reg[`DTC_BIT_CLKA_HI], mode_a_reg[`DTC_BIT_CLKA_LO]})
        `DTC_CLKA_DIV64:  tick_a = tick[`DTC_EXP_A64];  // R3
        `DTC_CLKA_DIV256: tick_a = tick[`DTC_EXP_A256]; // R3
        `DTC_CLKA_MATCH:  tick_a = hit_b;               // R3
        `DTC_CLKA_CARR:   tick_a = carr_rise;           // R3
        default:          tick_a = 1'b0;
      endcase
    end
    tick_a = tick_a & run_a_eff;
  end

  assign match_a = tick_a & ~casc & (cnt_a_reg == cmp_a_reg);

  // only the high phase match interrupts in carrier and pwm modes
  assign irq_b_evt = casc ? both_match : (hit_b & (~shaped | lvl_reg)); // R20 R21

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_a_reg <= `DTC_RST_REG;
    end else if (wr_mode_a) begin
      mode_a_reg <= wdat & `DTC_MASK_MODE_A; // R24
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_b_reg <= `DTC_RST_REG;
    end else if (wr_mode_b) begin
      mode_b_reg <= wdat & `DTC_MASK_MODE_B; // R24
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmp_a_reg    <= `DTC_RST_REG;
      cmp_b_lo_reg <= `DTC_RST_REG;
      cmp_b_hi_reg <= `DTC_RST_REG;
    end else begin
      if (wr & (idx == `DTC_IDX_CMP_A)) begin
        cmp_a_reg <= wdat;
      end
      if (wr & (idx == `DTC_IDX_CMP_B_LO)) begin
        cmp_b_lo_reg <= wdat;
      end
      if (wr & (idx == `DTC_IDX_CMP_B_HI)) begin
        cmp_b_hi_reg <= wdat;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rmc_reg <= 1'b0;
    end else if (wr_carr) begin
      rmc_reg <= wdat[`DTC_BIT_RMC];
    end
  end

  // a write of nrz_next wins over the loss on carrier stop
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      nrz_next_reg <= 1'b0;
    end else if (wr_carr) begin
      nrz_next_reg <= wdat[`DTC_BIT_NRZ_NEXT];
    end else if (wr_mode_b & ~wdat[`DTC_BIT_RUN] & (mode == DTC_CARR)) begin
      nrz_next_reg <= 1'b0; // R17
    end
  end

  // the hardware transfer wins over a software write in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      nrz_now_reg <= 1'b0;
    end else if (match_a & (mode == DTC_CARR)) begin
      nrz_now_reg <= nrz_next_reg; // R14
    end else if (wr_carr & ~mode_b_reg[`DTC_BIT_OE]) begin
      nrz_now_reg <= wdat[`DTC_BIT_NRZ_NOW]; // R16
    end
  end

  // ****************************************
  // counters
  // ****************************************
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_b_reg <= `DTC_RST_REG; // R1
    end else if (!run_b_eff) begin
      cnt_b_reg <= `DTC_RST_REG; // R9 R1
    end else if (both_match | hit_b) begin
      cnt_b_reg <= `DTC_RST_REG; // R1
    end else if (tick_b) begin
      cnt_b_reg <= cnt_b_reg + 8'h01; // overflow wraps to zero, R1
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_a_reg <= `DTC_RST_REG;
    end else if (!run_a_eff) begin
      cnt_a_reg <= `DTC_RST_REG; // R2 R9
    end else if (both_match | match_a) begin
      cnt_a_reg <= `DTC_RST_REG;
    end else if (tick_a) begin
      cnt_a_reg <= cnt_a_reg + 8'h01;
    end
  end

  // ****************************************
  // output shaping
  // ****************************************
  assign oe_rise = wr_mode_b & wdat[`DTC_BIT_OE] & ~mode_b_reg[`DTC_BIT_OE];

  // square wave in discrete and cascade, carrier phase in carrier and pwm
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lvl_reg <= 1'b0;
    end else if (oe_rise | ~run_b_eff) begin
      lvl_reg <= 1'b0; // R22
    end else if (hit_b | both_match) begin
      lvl_reg <= ~lvl_reg; // R23
    end
  end

  always_comb begin
    pin_next = lvl_reg;
    if (mode == DTC_CARR) begin
      if (!nrz_now_reg) begin
        pin_next = 1'b0; // R15
      end else begin
        pin_next = rmc_reg | lvl_reg; // R13 R23
      end
    end
    // low until the registered enable has caught up, so the pin starts low
    if (~oe_reg | ~mode_b_reg[`DTC_BIT_OE]) begin
      pin_next = 1'b0; // R22 R11
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_reg <= 1'b0;
      oe_reg  <= 1'b0;
    end else begin
      pin_reg <= pin_next;
      oe_reg  <= mode_b_reg[`DTC_BIT_OE]; // R11
    end
  end

  // ****************************************
  // match events
  // ****************************************
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_a_reg <= 1'b0;
      irq_b_reg <= 1'b0;
    end else begin
      irq_a_reg <= match_a; // R21
      irq_b_reg <= irq_b_evt;
    end
  end

  // ****************************************
  // read back
  // ****************************************
  always_comb begin
    case (idx)
      `DTC_IDX_MODE_A:   rd_byte = mode_a_reg;
      `DTC_IDX_MODE_B:   rd_byte = mode_b_reg;
      `DTC_IDX_CARRIER:  rd_byte = {5'h00, rmc_reg, nrz_next_reg, nrz_now_reg}; // R24
      `DTC_IDX_CMP_A:    rd_byte = cmp_a_reg;
      `DTC_IDX_CMP_B_LO: rd_byte = cmp_b_lo_reg;
      `DTC_IDX_CMP_B_HI: rd_byte = cmp_b_hi_reg;
      `DTC_IDX_CNT_A:    rd_byte = cnt_a_reg;
      `DTC_IDX_CNT_B:    rd_byte = cnt_b_reg;
      default:           rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= wb_hit;
      if (wb_hit) begin
        dat_reg <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_wb_ack       = ack_reg;
  assign o_wb_dat       = dat_reg;
  assign o_timer_out    = pin_reg;
  assign o_timer_out_oe = oe_reg;
  assign o_match_irq_a  = irq_a_reg;
  assign o_match_irq_b  = irq_b_reg;

endmodule
